// [fbmap_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module fbmap_bench;
  logic                  sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0]           paddr;
  logic [31:0]           pwdata, prdata, rd;
  logic                  cfg_valid, cfg_ok, cfg_done, out_valid, in_req, in_sel, in_ack;
  logic [4:0]            cfg_mod0, cfg_mod1;
  logic [2:0]            out_idx;
  logic [15:0]           out_word;
  logic [5:0]            in_idx;
  logic [7:0]            in_data, acy_wr_byte, acy_slot, acy_index, acy_rd_len, acy_rd_data;
  logic                  acy_wr_valid, acy_wr_first, acy_wr_last, acy_wr_ack, acy_wr_nack;
  logic                  acy_rd_req, acy_rd_err, acy_rd_valid, acy_rd_ready, acy_rd_last;
  logic [1:0]            res;
  logic [15:0]           img[3];
  fbmap_pkg::fbmap_cmd_t cmd;
  int                    mismatches, n_compared;
  int il[18] = '{0, 4, 1, 2, 0, 0, 2, 8, 10, 2, 4, 8, 16, 32, 0, 0, 32, 64};
  int ml[9]  = '{8, 1, 4, 5, 6, 7, 13, 14, 15};
  int ol[9]  = '{6, 2, 1, 2, 2, 4, 4, 2, 4};
  logic [7:0] fb[6] = '{8'h00, 8'ha5, 8'h11, 8'h22, 8'h33, 8'h44};

  fbmap_core fbmap_core_inst (.*);
  fbmap_dp_master fbmap_dp_master_inst (.*);

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // ==========================================================================
  // Checking and closing.
  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic tmo(input int n, lim);
    if (n >= lim) begin
      mismatches++;
      complete_run();
    end
  endtask
  // ==========================================================================
  // Port protocols.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (n = 0; n < 1 || pready !== 1'b1; n++) begin
      tmo(n, 20);
      @(posedge sys_clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rdx(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    check("apb_read", rd, x);
  endtask
  task automatic cfg(input logic [4:0] a, b, input logic ok);
    int n;
    cfg_valid <= 1'b1;
    cfg_mod0 <= a;
    cfg_mod1 <= b;
    @(posedge sys_clk);
    cfg_valid <= 1'b0;
    for (n = 0; n < 8 && cfg_done !== 1'b1; n++) @(posedge sys_clk);
    tmo(n, 8);
    check("cfg_ok", {31'h0, cfg_ok}, {31'h0, ok});
  endtask
  task automatic outw(input logic [2:0] i, input logic [15:0] w);
    out_valid <= 1'b1;
    out_idx <= i;
    out_word <= w;
    @(posedge sys_clk);
    out_valid <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic inb(input logic s, input logic [5:0] i, input logic [7:0] x);
    int n;
    in_req <= 1'b1;
    in_sel <= s;
    in_idx <= i;
    @(posedge sys_clk);
    in_req <= 1'b0;
    for (n = 0; n < 8 && in_ack !== 1'b1; n++) @(posedge sys_clk);
    tmo(n, 8);
    check("in_data", {24'h0, in_data}, {24'h0, x});
  endtask
  task automatic acy(input logic [7:0] sl, ix, input logic [1:0] x);
    fbmap_dp_master_inst.send(sl, ix, res);
    check("acy_resp", {30'h0, res}, {30'h0, x});
  endtask
  function automatic logic [6:0] ecmd(input int md, i);
    if (md == 0) return (i == 0) ? 7'h40 : (i == 2) ? 7'h20 : (i == 6) ? 7'h02 : 7'h00;
    return (i == 0) ? 7'h10 : (i == 1) ? 7'h08 : (i == 2 && md == 2) ? 7'h04 :
           (i == 3) ? 7'h02 : (i == 5) ? 7'h01 : 7'h00;
  endfunction
  // ==========================================================================
  // Main sequence.
  initial begin
    {rst_n, psel, penable, pwrite, cfg_valid, out_valid, in_req, in_sel} = 8'h0;
    {paddr, pwdata, cfg_mod0, cfg_mod1, out_idx, out_word, in_idx} = 79'h0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rdx(12'h000, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    check("pslverr", {31'h0, err}, 32'h1);
    cfg(5'h04, 5'h05, 1'b0);
    cfg(5'h01, 5'h07, 1'b0);
    cfg(5'h00, 5'h09, 1'b0);
    cfg(5'h12, 5'h00, 1'b0);
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, 12'h000, {31'h0, m == 2});
      cfg((m == 0) ? 5'h01 : 5'h06, 5'h00, 1'b1);
      for (int i = 0; i < 16; i++) begin
        outw(3'h0, 16'h0001 << i);
        check("cmd", {25'h0, cmd}, {25'h0, ecmd(m, i)});
      end
    end
    apb(1'b1, 12'h000, 32'h3);
    outw(3'h0, 16'h0021);
    check("cmd", {25'h0, cmd}, 32'h0);
    rdx(12'h200, 32'h0000_0021);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h008, 32'h1234_ffff);
    rdx(12'h008, 32'h1234_00cd);
    cfg(5'h01, 5'h09, 1'b1);
    for (int i = 0; i < 4; i++) inb(1'b0, 6'(i), 8'(32'h00cd_1234 >> (24 - 8 * i)));
    for (int i = 0; i < 32; i++)
      apb(1'b1, 12'h100 + 12'(4 * i), {16'h0, 8'(2 * i), 8'(2 * i + 1)});
    for (int m = 1; m < 18; m++) begin
      cfg(5'(m), 5'h09, 1'b1);
      inb(1'b1, 6'h0, (il[m] < 64) ? 8'(il[m]) : 8'h00);
    end
    for (int k = 0; k < 9; k++) begin
      cfg(5'(ml[k]), 5'h00, 1'b1);
      for (int j = 0; j < 3; j++) begin
        outw(3'(j), {8'(ml[k]), 8'(j)});
        if (2 * j < ol[k]) img[j] = {8'(ml[k]), 8'(j)};
      end
      for (int j = 0; j < 3; j++) rdx(12'h200 + 12'(4 * j), {16'h0, img[j]});
    end
    fbmap_dp_master_inst.fr = '{8'h06, 8'h00, 8'h10, 8'h00, 8'ha5};
    acy(8'h00, 8'h2d, 2'b10);
    rdx(12'h440, 32'h0000_00a5);
    fbmap_dp_master_inst.fr = '{8'h06, 8'h00, 8'h10, 8'h00, 8'h77};
    acy(8'h01, 8'h2d, 2'b01);
    acy(8'h00, 8'h2c, 2'b01);
    fbmap_dp_master_inst.fr = '{8'h06, 8'h01, 8'h00, 8'h00, 8'h77};
    acy(8'h00, 8'h2d, 2'b01);
    fbmap_dp_master_inst.fr = '{8'h10, 8'h00, 8'h10, 8'h00, 8'h77};
    acy(8'h00, 8'h2d, 2'b01);
    rdx(12'h440, 32'h0000_00a5);
    apb(1'b1, 12'h444, 32'h0000_1122);
    apb(1'b1, 12'h448, 32'h0000_3344);
    fbmap_dp_master_inst.fr = '{8'h03, 8'h00, 8'h10, 8'h03};
    acy(8'h00, 8'h2d, 2'b10);
    fbmap_dp_master_inst.fetch(8'h00, 8'h2d, 8'h04, err);
    check("fetch_err", {31'h0, err}, 32'h1);
    fbmap_dp_master_inst.fetch(8'h00, 8'h2c, 8'h06, err);
    check("fetch_err", {31'h0, err}, 32'h1);
    fbmap_dp_master_inst.stall = 1'b1;
    fbmap_dp_master_inst.fetch(8'h00, 8'h2d, 8'h06, err);
    check("fetch_err", {31'h0, err}, 32'h0);
    check("fetch_len", fbmap_dp_master_inst.got.size(), 32'h6);
    foreach (fbmap_dp_master_inst.got[i])
      check("fetch_byte", {24'h0, fbmap_dp_master_inst.got[i]}, {24'h0, fb[i]});
    fbmap_dp_master_inst.fetch(8'h00, 8'h2d, 8'h06, err);
    check("fetch_err", {31'h0, err}, 32'h1);
    complete_run();
  end
endmodule // fbmap_bench
`default_nettype wire

// [fbmap_core.sv]
// Function
// - At most two cyclic modules, and only one of them may carry output data.
// - An output module may hold no more than eight control words.
// - Profile module: one two-byte control word out, status plus current in.
// - Profile control: bit 0 reverse, bit 2 forward, bit 6 fault reset.
// - Profile status: bits 0,2,3,6,7 reverse, forward, overload, fault, warning.
// - Generic control: first_run_command, second_run_command, remote, reset, bit 5 test trip.
// - Remote switch acts only when allowed, and only via generic word.
// - Generic layout serves every output module except the profile.
// - Assigned bits exclude generic word; they occupy the first output word.
// - Modules 2 and 3 give one and two selectable input bytes.
// - Modules 4,5 output one and two bytes; module 6 two each way.
// - Modules 7, 8 and 13 carry 8/4, 10/6 and 32/4 bytes.
// - Modules 9 to 12 give 2, 4, 8 and 16 input bytes.
// - Modules 14 and 15 take two and four output bytes.
// - Modules 16 and 17 give 32 and 64 input bytes.
// - Parameter read: acyclic write with read request, then acyclic read.
// - Acyclic parameter access only at slot 0, index 45.
// - Read request: code 03, two-byte address, register count.
// - Fetch length is two bytes per requested register.
// - Write request: code 06, address, one data word stored.
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fbmap_defines.svh"
module fbmap_core #(
  parameter int PARAM_WORDS   = 256,
  parameter int MAX_CTL_WORDS = 8,
  parameter int MAX_RD_WORDS  = 8
) (
  // Clock and reset.
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  // APB slave.
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic      [31:0]          prdata,
  output logic                      pslverr,
  // Cyclic configuration.
  input  wire logic                 cfg_valid,
  input  wire logic [4:0]           cfg_mod0,
  input  wire logic [4:0]           cfg_mod1,
  output logic                      cfg_ok,
  output logic                      cfg_done,
  // Cyclic output data from the master.
  input  wire logic                 out_valid,
  input  wire logic [2:0]           out_idx,
  input  wire logic [15:0]          out_word,
  output var fbmap_pkg::fbmap_cmd_t cmd,
  // Cyclic input data to the master.
  input  wire logic                 in_req,
  input  wire logic                 in_sel,
  input  wire logic [5:0]           in_idx,
  output logic                      in_ack,
  output logic      [7:0]           in_data,
  // Acyclic write frame.
  input  wire logic                 acy_wr_valid,
  input  wire logic                 acy_wr_first,
  input  wire logic                 acy_wr_last,
  input  wire logic [7:0]           acy_wr_byte,
  input  wire logic [7:0]           acy_slot,
  input  wire logic [7:0]           acy_index,
  output logic                      acy_wr_ack,
  output logic                      acy_wr_nack,
  // Acyclic read frame.
  input  wire logic                 acy_rd_req,
  input  wire logic [7:0]           acy_rd_len,
  output logic                      acy_rd_err,
  output logic                      acy_rd_valid,
  input  wire logic                 acy_rd_ready,
  output logic      [7:0]           acy_rd_data,
  output logic                      acy_rd_last
);
  localparam int PW = $clog2(PARAM_WORDS);
  localparam logic [7:0] IN_LEN [0:17] = '{8'h00, 8'h04, 8'h01, 8'h02, 8'h00, 8'h00, 8'h02,
    8'h08, 8'h0a, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h00, 8'h00, 8'h20, 8'h40};
  localparam logic [7:0] OUT_LEN [0:17] = '{8'h00, 8'h02, 8'h00, 8'h00, 8'h01, 8'h02, 8'h02,
    8'h04, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h02, 8'h04, 8'h00, 8'h00};

  initial begin
    if (PARAM_WORDS < 2 || PARAM_WORDS > 256 || (1 << PW) != PARAM_WORDS)
      $error("PARAM_WORDS must be a power of two from 2 to 256");
    if (MAX_CTL_WORDS < 1 || MAX_CTL_WORDS > 8)
      $error("MAX_CTL_WORDS must be 1 to 8");
    if (MAX_RD_WORDS < 1 || MAX_RD_WORDS > 120)
      $error("MAX_RD_WORDS must be 1 to 120");
  end

  // ========================================================================
  // Register file.
  logic [31:0]            ctrl_reg;
  fbmap_pkg::fbmap_mstat_t mstat_reg;
  logic [15:0]            in_img   [0:31];
  logic [15:0]            out_img  [0:7];
  logic [15:0]            param    [0:PARAM_WORDS-1];
  logic [4:0]             mod0_reg;
  logic [4:0]             mod1_reg;
  logic                   allow_remote;
  logic                   bits_assigned;
  logic                   apb_wr;
  logic                   apb_setup;
  logic                   hit_img;
  logic                   hit_out;
  logic                   hit_par;
  logic                   mapped;
  logic [31:0]            rd_word;

  assign allow_remote  = ctrl_reg[0];
  assign bits_assigned = ctrl_reg[1];
  assign apb_setup     = psel && !penable;
  assign apb_wr        = psel && penable && pwrite;
  assign hit_img = paddr[11:7] == `FBMAP_INIMG_OFS >> 7 && paddr[1:0] == 2'b00;
  assign hit_out = paddr[11:5] == `FBMAP_OUTIMG_OFS >> 5 && paddr[1:0] == 2'b00;
  assign hit_par = paddr[11:10] == 2'b01 && int'(paddr[9:2]) < PARAM_WORDS
                   && paddr[1:0] == 2'b00;

  always_comb begin
    mapped  = 1'b1;
    rd_word = 32'h0000_0000;
    if (hit_img) begin
      rd_word = {16'h0000, in_img[paddr[6:2]]};
    end else if (hit_out) begin
      rd_word = {16'h0000, out_img[paddr[4:2]]};
    end else if (hit_par) begin
      rd_word = {16'h0000, param[paddr[PW+1:2]]};
    end else begin
      case (paddr)
        `FBMAP_CTRL_OFS:   rd_word = {30'h0, ctrl_reg[1:0]};
        `FBMAP_STATUS_OFS: rd_word = {21'h0, cfg_ok, mod1_reg, mod0_reg};
        `FBMAP_MSTAT_OFS:  rd_word = {mstat_reg.avg_current, 8'h00, mstat_reg.warning,
                                      mstat_reg.fault, 2'b00, mstat_reg.overload_warning,
                                      mstat_reg.running_forward, 1'b0,
                                      mstat_reg.running_reverse};
        `FBMAP_CMD_OFS:    rd_word = {25'h0, cmd};
        default:           mapped  = 1'b0;
      endcase
    end
  end

  // The answer is prepared in the setup phase, so the access phase is one cycle.
  assign pready = 1'b1;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      prdata  <= pwrite ? 32'h0000_0000 : rd_word;
      pslverr <= !mapped;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_reg  <= `FBMAP_CTRL_RST;
      mstat_reg <= fbmap_pkg::fbmap_mstat_t'(`FBMAP_MSTAT_RST);
    end else if (apb_wr && paddr == `FBMAP_CTRL_OFS) begin
      ctrl_reg <= {30'h0, pwdata[1:0]};
    end else if (apb_wr && paddr == `FBMAP_MSTAT_OFS) begin
      mstat_reg.avg_current      <= pwdata[31:16];
      mstat_reg.warning          <= pwdata[`FBMAP_PRF_WRN];
      mstat_reg.fault            <= pwdata[`FBMAP_PRF_FLT];
      mstat_reg.overload_warning <= pwdata[`FBMAP_PRF_OVL];
      mstat_reg.running_forward  <= pwdata[`FBMAP_PRF_FWD];
      mstat_reg.running_reverse  <= pwdata[`FBMAP_PRF_REV];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (apb_wr && hit_img) begin
      in_img[paddr[6:2]] <= pwdata[15:0];
    end
  end

  // ========================================================================
  // Cyclic configuration check.
  logic cfg_good;
  always_comb begin
    cfg_good = cfg_mod0 <= `FBMAP_MAX_MODULE && cfg_mod1 <= `FBMAP_MAX_MODULE
               && cfg_mod0 != 5'h00;
    if (OUT_LEN[cfg_mod0] != 8'h00 && OUT_LEN[cfg_mod1] != 8'h00)
      cfg_good = 1'b0;
    if (int'(OUT_LEN[cfg_mod0]) > 2 * MAX_CTL_WORDS || int'(OUT_LEN[cfg_mod1]) > 2 * MAX_CTL_WORDS)
      cfg_good = 1'b0;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cfg_ok   <= 1'b0;
      cfg_done <= 1'b0;
      mod0_reg <= 5'h00;
      mod1_reg <= 5'h00;
    end else begin
      cfg_done <= cfg_valid;
      if (cfg_valid) begin
        cfg_ok   <= cfg_good;
        mod0_reg <= cfg_good ? cfg_mod0 : 5'h00;
        mod1_reg <= cfg_good ? cfg_mod1 : 5'h00;
      end
    end
  end

  // ========================================================================
  // Cyclic output data and control word decode.
  logic [4:0] out_mod;
  logic       out_take;
  assign out_mod  = OUT_LEN[mod0_reg] != 8'h00 ? mod0_reg : mod1_reg;
  assign out_take = out_valid && cfg_ok && {4'h0, out_idx, 1'b0} < OUT_LEN[out_mod];

  always_ff @(posedge sys_clk) begin
    if (out_take) begin
      out_img[out_idx] <= out_word;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || !cfg_ok) begin
      cmd <= '0;
    end else if (out_take && out_idx == 3'h0) begin
      cmd <= '0;
      if (out_mod == `FBMAP_PROFILE_ID) begin
        cmd.run_reverse <= out_word[`FBMAP_PRF_REV];
        cmd.run_forward <= out_word[`FBMAP_PRF_FWD];
        cmd.fault_reset <= out_word[`FBMAP_PRF_RST];
      end else if (!bits_assigned) begin
        cmd.first_run_command  <= out_word[`FBMAP_GEN_FIRST_RUN_COMMAND];
        cmd.second_run_command <= out_word[`FBMAP_GEN_SECOND_RUN_COMMAND];
        cmd.fault_reset        <= out_word[`FBMAP_GEN_RESET];
        cmd.test_trip          <= out_word[`FBMAP_GEN_TRIP];
        cmd.switch_to_remote   <= out_word[`FBMAP_GEN_REMOTE] && allow_remote;
      end
    end else if (!allow_remote) begin
      cmd.switch_to_remote <= 1'b0;
    end
  end

  // ========================================================================
  // Cyclic input data.
  logic [4:0]  in_mod;
  logic [6:0]  in_pos;
  logic [15:0] prf_status;
  assign in_mod = in_sel ? mod1_reg : mod0_reg;
  assign in_pos = {1'b0, in_idx} + (in_sel ? IN_LEN[mod0_reg][6:0] : 7'h00);
  assign prf_status = {8'h00, mstat_reg.warning, mstat_reg.fault, 2'b00,
                       mstat_reg.overload_warning, mstat_reg.running_forward, 1'b0,
                       mstat_reg.running_reverse};

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      in_ack  <= 1'b0;
      in_data <= 8'h00;
    end else begin
      in_ack  <= in_req;
      in_data <= 8'h00;
      if (in_req && cfg_ok && {2'b00, in_idx} < IN_LEN[in_mod]) begin
        if (in_mod == `FBMAP_PROFILE_ID) begin
          case (in_idx[1:0])
            2'b00:   in_data <= prf_status[15:8];
            2'b01:   in_data <= prf_status[7:0];
            2'b10:   in_data <= mstat_reg.avg_current[15:8];
            default: in_data <= mstat_reg.avg_current[7:0];
          endcase
        end else if (!in_pos[6]) begin
          in_data <= in_pos[0] ? in_img[in_pos[5:1]][7:0] : in_img[in_pos[5:1]][15:8];
        end
      end
    end
  end

  // ========================================================================
  // Acyclic parameter channel.
  fbmap_pkg::fbmap_acy_state_t state;
  logic [7:0]  buf_b [0:5];
  logic [3:0]  rx_cnt;
  logic        rx_ok;
  logic [15:0] req_addr;
  logic [15:0] req_data;
  logic        pend;
  logic [PW-1:0] rd_ptr;
  logic [7:0]  rd_left;
  logic        rd_lo;
  logic        frame_end;
  logic        wr_exec;
  logic        rd_setup;
  logic [4:0]  f_len;
  logic [16:0] f_end;
  logic        rd_go;

  assign frame_end = acy_wr_valid && acy_wr_last;
  assign f_len     = acy_wr_first ? 5'h01 : {1'b0, rx_cnt} + 5'h01;
  assign req_addr  = {buf_b[1], buf_b[2]};
  assign req_data  = {buf_b[3], buf_b[4]};
  assign f_end     = {1'b0, req_addr} + {9'h000, acy_wr_byte};
  assign rd_setup  = frame_end && rx_ok && state == fbmap_pkg::ACY_IDLE
                     && buf_b[0] == `FBMAP_CMD_READ && f_len == {1'b0, `FBMAP_RD_REQ_LEN}
                     && acy_wr_byte != 8'h00 && int'(acy_wr_byte) <= MAX_RD_WORDS
                     && int'(f_end) <= PARAM_WORDS;
  assign wr_exec   = frame_end && rx_ok && state == fbmap_pkg::ACY_IDLE
                     && buf_b[0] == `FBMAP_CMD_WRITE && f_len == {1'b0, `FBMAP_WR_REQ_LEN}
                     && int'({buf_b[1], buf_b[2]}) < PARAM_WORDS;
  assign rd_go     = acy_rd_req && pend && state == fbmap_pkg::ACY_IDLE
                     && acy_slot == `FBMAP_ACY_SLOT && acy_index == `FBMAP_ACY_INDEX
                     && acy_rd_len == {rd_left[6:0], 1'b0} && !rd_setup;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rx_cnt <= 4'h0;
      rx_ok  <= 1'b0;
    end else if (acy_wr_valid) begin
      if (acy_wr_first) begin
        rx_ok <= acy_slot == `FBMAP_ACY_SLOT && acy_index == `FBMAP_ACY_INDEX;
      end else if (rx_cnt == 4'h6) begin
        rx_ok <= 1'b0;
      end
      rx_cnt <= acy_wr_last ? 4'h0 : f_len[3:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (acy_wr_valid && f_len <= 5'h06) begin
      buf_b[f_len[2:0] - 3'h1] <= acy_wr_byte;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (wr_exec) begin
      param[req_addr[PW-1:0]] <= {buf_b[3], acy_wr_byte};
    end else if (apb_wr && hit_par) begin
      param[paddr[PW+1:2]] <= pwdata[15:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      acy_wr_ack  <= 1'b0;
      acy_wr_nack <= 1'b0;
      acy_rd_err  <= 1'b0;
    end else begin
      acy_wr_ack  <= rd_setup || wr_exec;
      acy_wr_nack <= frame_end && !(rd_setup || wr_exec);
      acy_rd_err  <= acy_rd_req && !rd_go;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state       <= fbmap_pkg::ACY_IDLE;
      pend        <= 1'b0;
      rd_ptr      <= '0;
      rd_left     <= 8'h00;
      rd_lo       <= 1'b0;
      acy_rd_data <= 8'h00;
    end else begin
      case (state)
        fbmap_pkg::ACY_IDLE: begin
          if (rd_setup) begin
            pend    <= 1'b1;
            rd_ptr  <= req_addr[PW-1:0];
            rd_left <= acy_wr_byte;
          end else if (rd_go) begin
            rd_lo <= 1'b0;
            state <= fbmap_pkg::ACY_LOAD;
          end
        end
        fbmap_pkg::ACY_LOAD: begin
          acy_rd_data <= rd_lo ? param[rd_ptr][7:0] : param[rd_ptr][15:8];
          state       <= fbmap_pkg::ACY_SEND;
        end
        fbmap_pkg::ACY_SEND: begin
          if (acy_rd_ready) begin
            rd_lo <= !rd_lo;
            state <= fbmap_pkg::ACY_LOAD;
            if (rd_lo) begin
              rd_ptr  <= rd_ptr + 1'b1;
              rd_left <= rd_left - 8'h01;
              if (rd_left == 8'h01) begin
                pend  <= 1'b0;
                state <= fbmap_pkg::ACY_IDLE;
              end
            end
          end
        end
        default: state <= fbmap_pkg::ACY_IDLE;
      endcase
    end
  end

  assign acy_rd_valid = state == fbmap_pkg::ACY_SEND;
  assign acy_rd_last  = acy_rd_valid && rd_lo && rd_left == 8'h01;

  // ========================================================================
  // Checks.
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_one_output: assert property (cfg_ok |-> !(OUT_LEN[mod0_reg] != 8'h00
    && OUT_LEN[mod1_reg] != 8'h00)) else $error("two output modules accepted");
  chk_ctl_words: assert property (cfg_ok |-> int'(OUT_LEN[out_mod]) <= 2 * MAX_CTL_WORDS)
    else $error("output module too large");
  chk_prf_input: assert property (in_req && cfg_ok && !in_sel && mod0_reg == 5'h01
    && in_idx == 6'h01 |=> in_data == {$past(mstat_reg.warning), $past(mstat_reg.fault), 2'b00,
    $past(mstat_reg.overload_warning), $past(mstat_reg.running_forward), 1'b0,
    $past(mstat_reg.running_reverse)}) else $error("profile input mismatch");
  chk_prf_reverse: assert property (out_take && out_idx == 3'h0 && out_mod == 5'h01
    |=> cmd.run_reverse == $past(out_word[0]) && !cmd.first_run_command)
    else $error("profile reverse not decoded");
  chk_gen_trip: assert property (out_take && out_idx == 3'h0 && out_mod != 5'h01
    && !bits_assigned |=> cmd.test_trip == $past(out_word[5]) && !cmd.run_forward)
    else $error("generic trip not decoded");
  chk_remote_gate: assert property (cmd.switch_to_remote |->
    allow_remote || $past(allow_remote)) else $error("remote switch without permission");
  chk_status_rsvd: assert property (prf_status[15:8] == 8'h00 && !prf_status[1]
    && prf_status[5:4] == 2'b00) else $error("reserved status bit set");
  chk_rd_fetch: assert property (rd_go |=> state == fbmap_pkg::ACY_LOAD ##1 acy_rd_valid)
    else $error("fetch did not start");
  chk_bad_slot: assert property (frame_end && !acy_wr_first && !rx_ok |=> acy_wr_nack
    && !acy_wr_ack) else $error("wrong slot accepted");
  chk_wr_store: assert property (wr_exec |=> param[$past(req_addr[PW-1:0])]
    == {$past(buf_b[3]), $past(acy_wr_byte)}) else $error("parameter not stored");
endmodule // fbmap_core
`default_nettype wire

// [fbmap_defines.svh]
`ifndef FBMAP_DEFINES_SVH
`define FBMAP_DEFINES_SVH
// ==========================================================================
// Register offsets (byte addresses).
`define FBMAP_CTRL_OFS      12'h000
`define FBMAP_STATUS_OFS    12'h004
`define FBMAP_MSTAT_OFS     12'h008
`define FBMAP_CMD_OFS       12'h00c
`define FBMAP_INIMG_OFS     12'h100
`define FBMAP_OUTIMG_OFS    12'h200
`define FBMAP_PARAM_OFS     12'h400
`define FBMAP_CTRL_RST      32'h0000_0000
`define FBMAP_MSTAT_RST     32'h0000_0000
// ==========================================================================
// Acyclic channel constants.
`define FBMAP_ACY_SLOT      8'h00
`define FBMAP_ACY_INDEX     8'h2d
`define FBMAP_CMD_READ      8'h03
`define FBMAP_CMD_WRITE     8'h06
`define FBMAP_RD_REQ_LEN    4'h4
`define FBMAP_WR_REQ_LEN    4'h5
// ==========================================================================
// Control and status word bit positions.
`define FBMAP_PRF_REV       0
`define FBMAP_PRF_FWD       2
`define FBMAP_PRF_OVL       3
`define FBMAP_PRF_RST       6
`define FBMAP_PRF_FLT       6
`define FBMAP_PRF_WRN       7
`define FBMAP_GEN_FIRST_RUN_COMMAND      0
`define FBMAP_GEN_SECOND_RUN_COMMAND      1
`define FBMAP_GEN_REMOTE    2
`define FBMAP_GEN_RESET     3
`define FBMAP_GEN_TRIP      5
`define FBMAP_PROFILE_ID    5'h01
`define FBMAP_MAX_MODULE    5'h11
`endif

// [fbmap_dp_master.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Acyclic side of the bus master: sends frames and fetches results.
module fbmap_dp_master (
  // Clock.
  input  wire logic       sys_clk,
  // Acyclic write frame.
  output logic            acy_wr_valid,
  output logic            acy_wr_first,
  output logic            acy_wr_last,
  output logic      [7:0] acy_wr_byte,
  output logic      [7:0] acy_slot,
  output logic      [7:0] acy_index,
  input  wire logic       acy_wr_ack,
  input  wire logic       acy_wr_nack,
  // Acyclic read frame.
  output logic            acy_rd_req,
  output logic      [7:0] acy_rd_len,
  input  wire logic       acy_rd_err,
  input  wire logic       acy_rd_valid,
  output logic            acy_rd_ready,
  input  wire logic [7:0] acy_rd_data,
  input  wire logic       acy_rd_last
);
  logic [7:0] fr[$];
  logic [7:0] got[$];
  bit         stall;
  initial begin
    {acy_wr_valid, acy_wr_first, acy_wr_last, acy_rd_req} = 4'h0;
    {acy_wr_byte, acy_slot, acy_index, acy_rd_len} = 32'h0;
    acy_rd_ready = 1'b1;
  end
  // Frame bytes go out one per cycle; slot and index stand for the frame.
  task automatic send(input logic [7:0] sl, ix, output logic [1:0] res);
    int n;
    res = 2'b00;
    foreach (fr[i]) begin
      acy_wr_valid <= 1'b1;
      acy_wr_first <= (i == 0);
      acy_wr_last  <= (i == fr.size() - 1);
      acy_wr_byte  <= fr[i];
      acy_slot     <= sl;
      acy_index    <= ix;
      @(posedge sys_clk);
    end
    {acy_wr_valid, acy_wr_first, acy_wr_last} <= 3'h0;
    acy_wr_byte <= ~acy_wr_byte;
    acy_slot    <= ~sl;
    for (n = 0; n < 6 && res == 2'b00; n++) begin
      @(posedge sys_clk);
      res = {acy_wr_ack, acy_wr_nack};
    end
  endtask
  // Fetch asks for the len bytes given by the caller; optional stalls in two cycles of four.
  task automatic fetch(input logic [7:0] sl, ix, len, output logic err);
    int n;
    got.delete();
    err = 1'b0;
    acy_rd_req <= 1'b1;
    acy_rd_len <= len;
    acy_slot   <= sl;
    acy_index  <= ix;
    @(posedge sys_clk);
    acy_rd_req <= 1'b0;
    acy_rd_len <= ~len;
    for (n = 0; n < 40; n++) begin
      acy_rd_ready <= stall ? n[1] : 1'b1;
      @(posedge sys_clk);
      if (acy_rd_err === 1'b1) err = 1'b1;
      if (acy_rd_valid === 1'b1 && acy_rd_ready === 1'b1) begin
        got.push_back(acy_rd_data);
        if (acy_rd_last === 1'b1) break;
      end
    end
    acy_rd_ready <= 1'b1;
  endtask
endmodule // fbmap_dp_master
`default_nettype wire

// [fbmap_pkg.sv]
package fbmap_pkg;
  typedef enum logic [1:0] {ACY_IDLE, ACY_LOAD, ACY_SEND} fbmap_acy_state_t;
  typedef struct packed {
    logic run_reverse;
    logic run_forward;
    logic first_run_command;
    logic second_run_command;
    logic switch_to_remote;
    logic fault_reset;
    logic test_trip;
  } fbmap_cmd_t;
  typedef struct packed {
    logic        running_reverse;
    logic        running_forward;
    logic        overload_warning;
    logic        fault;
    logic        warning;
    logic [15:0] avg_current;
  } fbmap_mstat_t;
endpackage
